// ### qsd_enc_model.sv
`timescale 1ns/1ns
// ==========================================
// Encoder stand-in: one phase per move; both only when told to fault
module qsd_enc_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic [1:0] op,
  output logic a,
  output logic b
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a <= 1'b0;
      b <= 1'b0;
    end else if (go) begin
      case (op)
        2'h1: {a, b} <= {b, ~a};
        2'h2: {a, b} <= {~b, a};
        // Injected fault, only on request
        2'h3: {a, b} <= {~a, ~b};
        default: ;
      endcase
    end
  end
endmodule : qsd_enc_model

// ### qsd_map.svh
`ifndef QSD_MAP_SVH
`define QSD_MAP_SVH
// ==========================================
// Register offsets
`define QSD_OFF_TASK 8'h00
`define QSD_OFF_PERIOD 8'h04
`define QSD_OFF_STEP 8'h08
`define QSD_OFF_ACC 8'h0c
`define QSD_OFF_DBL 8'h10
`define QSD_OFF_EVENT 8'h14
`define QSD_OFF_MASK 8'h18
`define QSD_OFF_STATUS 8'h1c
// ==========================================
// Task bits in the task register
`define QSD_TASK_START 0
`define QSD_TASK_STOP 1
`define QSD_TASK_CLR_ACC 2
`define QSD_TASK_CLR_DBL 3
// ==========================================
// Event bits, shared by the event and mask registers
`define QSD_EV_STEP 0
`define QSD_EV_OVF 1
`define QSD_EV_STOP 2
`define QSD_EV_W 3
// ==========================================
// Reset values
`define QSD_PERIOD_RST 16'h0063
`define QSD_MASK_RST 3'h0
`endif

// ### qsd_pkg.sv
package qsd_pkg;
  // ==========================================
  // Phase pair and sequencer states
  typedef struct packed {
    logic a;
    logic b;
  } qsd_pair_t;
  typedef enum logic [1:0] {
    QSD_IDLE,
    QSD_PRIME,
    QSD_RUN
  } qsd_state_t;
  typedef struct packed {
    logic start;
    logic stop;
    logic clr_acc;
    logic clr_dbl;
  } qsd_task_t;
endpackage : qsd_pkg

// ### qsd_top.sv
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "qsd_map.svh"
// Operation
// - Both phases are sampled once per programmed sample period.
// - After start, sampling continues; each pair is compared with the previous one.
// - Unchanged pair gives step 0; accumulator and double counter stay.
// - Forward transitions give step 1 and increment the accumulator.
// - Reverse transitions give step -1 and decrement the accumulator.
// - Both phases changed gives step 2 and bumps the double counter only.
// - Accumulator adds every +1 or -1 step that does not overflow, never a double step.
// - A step that would overflow is dropped and raises the overflow event.
// - Each new step value written raises the step ready event.
// - Once sampling has ceased after stop, the stopped event is raised.
module qsd_top #(
  parameter int PER_W = 16,
  parameter int ACC_W = 16,
  parameter int DBL_W = 4
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  output logic RUNNING
);
  // ==========================================
  // Input synchronisers
  qsd_pkg::qsd_pair_t pin_meta;
  qsd_pkg::qsd_pair_t pin_sync;
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= '{a: PHASE_A, b: PHASE_B};
      pin_sync <= pin_meta;
    end
  end

  // ==========================================
  // Bus decode
  qsd_pkg::qsd_task_t task_req;
  logic wr_task;
  logic wr_period;
  logic wr_event;
  logic wr_mask;
  always_comb begin
    wr_task = 1'b0;
    wr_period = 1'b0;
    wr_event = 1'b0;
    wr_mask = 1'b0;
    if (WR && ADDR == `QSD_OFF_TASK) begin
      wr_task = 1'b1;
    end else if (WR && ADDR == `QSD_OFF_PERIOD) begin
      wr_period = 1'b1;
    end else if (WR && ADDR == `QSD_OFF_EVENT) begin
      wr_event = 1'b1;
    end else if (WR && ADDR == `QSD_OFF_MASK) begin
      wr_mask = 1'b1;
    end
    task_req.start = wr_task & WDATA[`QSD_TASK_START];
    task_req.stop = wr_task & WDATA[`QSD_TASK_STOP];
    task_req.clr_acc = wr_task & WDATA[`QSD_TASK_CLR_ACC];
    task_req.clr_dbl = wr_task & WDATA[`QSD_TASK_CLR_DBL];
  end

  // ==========================================
  // Sampler and decoder
  qsd_pkg::qsd_state_t state;
  qsd_pkg::qsd_state_t next_state;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] next_period;
  logic [PER_W-1:0] timer;
  logic [PER_W-1:0] next_timer;
  qsd_pkg::qsd_pair_t prev;
  qsd_pkg::qsd_pair_t next_prev;
  logic signed [2:0] step;
  logic signed [2:0] next_step;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;
  logic [DBL_W-1:0] dbl;
  logic [DBL_W-1:0] next_dbl;
  logic fire;
  logic ev_step;
  logic ev_ovf;
  logic ev_stop;
  logic [1:0] diff;
  logic fwd;

  always_comb begin
    next_state = state;
    next_period = period;
    next_timer = timer;
    next_prev = prev;
    next_step = step;
    next_acc = task_req.clr_acc ? '0 : acc;
    next_dbl = task_req.clr_dbl ? '0 : dbl;
    ev_step = 1'b0;
    ev_ovf = 1'b0;
    ev_stop = 1'b0;
    diff = {prev.a ^ pin_sync.a, prev.b ^ pin_sync.b};
    fwd = (pin_sync.a == prev.b);
    fire = (state != qsd_pkg::QSD_IDLE) && (timer == '0);
    if (wr_period) begin
      next_period = WDATA[PER_W-1:0];
    end
    if (state != qsd_pkg::QSD_IDLE) begin
      next_timer = fire ? period : timer - 1'b1;
    end
    if (task_req.stop && state != qsd_pkg::QSD_IDLE) begin
      next_state = qsd_pkg::QSD_IDLE;
      ev_stop = 1'b1;
    end else if (task_req.start && state == qsd_pkg::QSD_IDLE) begin
      next_state = qsd_pkg::QSD_PRIME;
      next_timer = period;
    end else if (fire && state == qsd_pkg::QSD_PRIME) begin
      next_prev = pin_sync;
      next_state = qsd_pkg::QSD_RUN;
    end else if (fire) begin
      next_prev = pin_sync;
      ev_step = 1'b1;
      if (diff == 2'b00) begin
        next_step = 3'sh0;
      end else if (diff == 2'b11) begin
        next_step = 3'sh2;
        if (&next_dbl) begin
          ev_ovf = 1'b1;
        end else begin
          next_dbl = next_dbl + 1'b1;
        end
      end else if (fwd) begin
        next_step = 3'sh1;
        if (next_acc == {1'b0, {(ACC_W-1){1'b1}}}) begin
          ev_ovf = 1'b1;
        end else begin
          next_acc = next_acc + 1'b1;
        end
      end else begin
        next_step = -3'sh1;
        if (next_acc == {1'b1, {(ACC_W-1){1'b0}}}) begin
          ev_ovf = 1'b1;
        end else begin
          next_acc = next_acc - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state <= qsd_pkg::QSD_IDLE;
      period <= `QSD_PERIOD_RST;
      timer <= '0;
      prev <= '0;
      step <= '0;
      acc <= '0;
      dbl <= '0;
    end else begin
      state <= next_state;
      period <= next_period;
      timer <= next_timer;
      prev <= next_prev;
      step <= next_step;
      acc <= next_acc;
      dbl <= next_dbl;
    end
  end

  // ==========================================
  // Events, mask, interrupt and read data
  logic [`QSD_EV_W-1:0] events;
  logic [`QSD_EV_W-1:0] next_events;
  logic [`QSD_EV_W-1:0] mask;
  logic [`QSD_EV_W-1:0] next_mask;
  logic [31:0] next_rdata;
  logic next_irq;

  always_comb begin
    next_mask = wr_mask ? WDATA[`QSD_EV_W-1:0] : mask;
    // A new event in the clearing cycle survives the clear
    next_events = events & ~(wr_event ? WDATA[`QSD_EV_W-1:0] : '0);
    next_events[`QSD_EV_STEP] = next_events[`QSD_EV_STEP] | ev_step;
    next_events[`QSD_EV_OVF] = next_events[`QSD_EV_OVF] | ev_ovf;
    next_events[`QSD_EV_STOP] = next_events[`QSD_EV_STOP] | ev_stop;
    next_irq = |(next_events & next_mask);
    next_rdata = '0;
    if (RD && ADDR == `QSD_OFF_PERIOD) begin
      next_rdata[PER_W-1:0] = period;
    end else if (RD && ADDR == `QSD_OFF_STEP) begin
      next_rdata = 32'(step);
    end else if (RD && ADDR == `QSD_OFF_ACC) begin
      next_rdata = 32'(acc);
    end else if (RD && ADDR == `QSD_OFF_DBL) begin
      next_rdata[DBL_W-1:0] = dbl;
    end else if (RD && ADDR == `QSD_OFF_EVENT) begin
      next_rdata[`QSD_EV_W-1:0] = events;
    end else if (RD && ADDR == `QSD_OFF_MASK) begin
      next_rdata[`QSD_EV_W-1:0] = mask;
    end else if (RD && ADDR == `QSD_OFF_STATUS) begin
      next_rdata[0] = (state != qsd_pkg::QSD_IDLE);
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      events <= '0;
      mask <= `QSD_MASK_RST;
      RDATA <= '0;
      IRQ <= 1'b0;
      RUNNING <= 1'b0;
    end else begin
      events <= next_events;
      mask <= next_mask;
      RDATA <= next_rdata;
      IRQ <= next_irq;
      RUNNING <= (next_state != qsd_pkg::QSD_IDLE);
    end
  end

  // ==========================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  period_reload_a: assert property (fire && !task_req.stop |=> timer == $past(period))
    else $error("timer not reloaded after sample");
  keep_sampling_a: assert property (state == qsd_pkg::QSD_RUN && !task_req.stop
    |=> state == qsd_pkg::QSD_RUN)
    else $error("sampling paused without stop");
  still_pair_a: assert property (fire && state == qsd_pkg::QSD_RUN && diff == 2'b00
    && !task_req.stop && !task_req.clr_acc |=> step == 3'sh0 && $stable(acc))
    else $error("still pair changed accumulator");
  fwd_step_a: assert property (fire && state == qsd_pkg::QSD_RUN && !task_req.stop
    && diff != 2'b00 && diff != 2'b11 && fwd && !task_req.clr_acc
    && acc != {1'b0, {(ACC_W-1){1'b1}}}
    |=> step == 3'sh1 && acc == $past(acc) + 1'b1)
    else $error("forward step not counted");
  rev_step_a: assert property (fire && state == qsd_pkg::QSD_RUN && !task_req.stop
    && diff != 2'b00 && diff != 2'b11 && !fwd && !task_req.clr_acc
    && acc != {1'b1, {(ACC_W-1){1'b0}}}
    |=> step == -3'sh1 && acc == $past(acc) - 1'b1)
    else $error("reverse step not counted");
  dbl_step_a: assert property (fire && state == qsd_pkg::QSD_RUN && diff == 2'b11
    && !task_req.stop && !task_req.clr_acc |=> step == 3'sh2 && $stable(acc))
    else $error("double transition mishandled");
  acc_ovf_a: assert property (ev_ovf |=> events[`QSD_EV_OVF] ##1 1'b1)
    else $error("overflow event lost");
  step_ready_a: assert property (state == qsd_pkg::QSD_RUN && fire && !task_req.stop
    |=> events[`QSD_EV_STEP])
    else $error("step ready not raised");
  stop_event_a: assert property (task_req.stop && state != qsd_pkg::QSD_IDLE
    |=> events[`QSD_EV_STOP] && state == qsd_pkg::QSD_IDLE && !RUNNING)
    else $error("stop did not stop");
  prime_quiet_a: assert property (state == qsd_pkg::QSD_PRIME |-> !ev_step)
    else $error("step produced while priming");

  start_run_c: cover property (task_req.start ##[1:300] state == qsd_pkg::QSD_RUN);
  ovf_hit_c: cover property (ev_ovf);
  dbl_hit_c: cover property (fire && diff == 2'b11 && state == qsd_pkg::QSD_RUN);
  irq_hit_c: cover property (IRQ ##1 wr_event);
endmodule : qsd_top

// ### qsd_top_test.sv
`timescale 1ns/1ns
`include "qsd_map.svh"
module qsd_top_test;
  localparam int PER = 23;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [1:0] op = 2'h0;
  logic pa;
  logic pb;
  logic irq;
  logic running;
  logic [31:0] rdata;
  logic [31:0] got;
  int err_count = 0;
  int n_compared = 0;
  int acc = 0;
  int dbl = 0;
  int ovf = 0;
  int n;
  // Each row is the encoder move and also the step value it must give
  int rows[17] = '{0, 1, 0, 1, 0, 1, 0, 1, -1, -1, -1, 2, 2, -1, 2, 2, -1};

  always #5 clk = ~clk;

  qsd_enc_model u_enc (.clk(clk), .rstn(rstn), .go(go), .op(op), .a(pa), .b(pb));

  qsd_top u_dut (
    .CLK(clk), .RSTN(rstn), .PHASE_A(pa), .PHASE_B(pb), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq), .RUNNING(running)
  );

  // ==========================================
  // Bus and compare helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdata;
    chk(name, exp, got);
  endtask : rd_chk

  task automatic wait_irq(output int cnt);
    cnt = 0;
    while (irq !== 1'b1 && cnt < 400) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    if (cnt >= 400) chk("irq_wait", 32'h1, 32'h0);
  endtask : wait_irq

  // Move the encoder and clear step ready together, then judge the next sample
  task automatic run_row(input int c);
    @(posedge clk);
    op <= (c == -1) ? 2'h2 : (c == 2) ? 2'h3 : c[1:0];
    go <= 1'b1;
    addr <= `QSD_OFF_EVENT;
    wdata <= 32'h1;
    wr <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    wait_irq(n);
    if (c == 1 || c == -1) acc += c;
    if (c == 2 && dbl == 15) ovf = 1;
    else if (c == 2) dbl++;
    rd_chk("step", `QSD_OFF_STEP, c);
    rd_chk("acc", `QSD_OFF_ACC, acc);
    rd_chk("dbl", `QSD_OFF_DBL, dbl);
    rd_chk("event", `QSD_OFF_EVENT, 32'h1 | (ovf << 1));
  endtask : run_row

  task automatic test_done;
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("period_rst", `QSD_OFF_PERIOD, 32'h63);
    rd_chk("mask_rst", `QSD_OFF_MASK, 32'h0);
    rd_chk("unmapped", 8'h20, 32'h0);
    rd_chk("task_read", `QSD_OFF_TASK, 32'h0);
    wr_reg(`QSD_OFF_PERIOD, PER);
    rd_chk("period_rw", `QSD_OFF_PERIOD, PER);
    wr_reg(`QSD_OFF_MASK, 32'h1);
    wr_reg(`QSD_OFF_TASK, 32'h1);
    wait_irq(n);
    chk("first_gap", 32'h1, {31'h0, (n >= 2 * PER) && (n <= 2 * PER + 4)});
    chk("running", 32'h1, {31'h0, running});
    for (int i = 0; i < 29; i++) run_row(i < 17 ? rows[i] : 2);
    wr_reg(`QSD_OFF_TASK, 32'hc);
    rd_chk("acc_clr", `QSD_OFF_ACC, 32'h0);
    rd_chk("dbl_clr", `QSD_OFF_DBL, 32'h0);
    wr_reg(`QSD_OFF_TASK, 32'h2);
    wr_reg(`QSD_OFF_EVENT, 32'h3);
    rd_chk("stopped_ev", `QSD_OFF_EVENT, 32'h4);
    rd_chk("status", `QSD_OFF_STATUS, 32'h0);
    chk("run_low", 32'h0, {31'h0, running});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr_reg(`QSD_OFF_MASK, 32'h4);
    repeat (3) @(posedge clk);
    #1;
    chk("irq_on", 32'h1, {31'h0, irq});
    wr_reg(`QSD_OFF_EVENT, 32'h4);
    repeat (3) @(posedge clk);
    #1;
    chk("irq_off", 32'h0, {31'h0, irq});
    wr_reg(`QSD_OFF_TASK, 32'h2);
    rd_chk("idle_stop", `QSD_OFF_EVENT, 32'h0);
    // Reset in mid-run must drop the decoder back to its reset state
    wr_reg(`QSD_OFF_TASK, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("run_high", 32'h1, {31'h0, running});
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    chk("rst_run", 32'h0, {31'h0, running});
    chk("rst_rdata", 32'h0, rdata);
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_chk("period_rst2", `QSD_OFF_PERIOD, 32'h63);
    @(posedge clk);
    #1;
    chk("rdata_idle", 32'h0, rdata);
    rd_chk("status_rst", `QSD_OFF_STATUS, 32'h0);
    test_done();
  end

  // Rows take one sample period, 24 cycles, each; this leaves ample room
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    test_done();
  end
endmodule : qsd_top_test
